// File: lcr_cell.sv
`timescale 1ns/1ps
package lcr_pkg;
    // ==========================================================
    // Fabric geometry
    localparam int CPC        = 8;
    localparam int DATA_W     = 4;
    localparam int LUT_BITS   = 16;
    localparam int D1_BIT     = 0;
    localparam int D3_BIT     = 2;
    // ==========================================================
    // Register map
    localparam int          ADDR_W    = 12;
    localparam logic [11:0] CTRL_OFF  = 12'h000;
    localparam logic [11:0] DIV_OFF   = 12'h004;
    localparam logic [11:0] OUT_OFF   = 12'h008;
    localparam logic [11:0] COMB_OFF  = 12'h00c;
    localparam logic [11:0] CLUS_BASE = 12'h080;
    localparam logic [11:0] CELL_BASE = 12'h100;
    localparam int          CTRL_B_LSB = 8;
    localparam int          CTRL_W     = 16;
    localparam int          DIV_W      = 16;
    // Cell word fields
    localparam int          CFG_MODE   = 16;
    localparam int          CFG_CHAIN  = 18;
    localparam int          CFG_CASC_OR = 19;
    localparam int          CFG_INV    = 20;
    localparam int          CFG_CE_D1  = 21;
    localparam int          CFG_W      = 22;
    localparam int          SCHEME_W   = 3;
    localparam logic [21:0] CFG_RESET  = 22'h000000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DIV_RESET  = 16'h0000;
    localparam logic        RESP_OKAY  = 1'b0;
    // ==========================================================
    // Modes and asynchronous control schemes
    typedef enum logic [1:0] {
        LCR_NORMAL, LCR_ARITH, LCR_UPDOWN, LCR_CLRCNT
    } lcr_mode_e;
    typedef enum logic [2:0] {
        LCR_ASYNC_NONE, LCR_ASYNC_CLR, LCR_ASYNC_PRE, LCR_ASYNC_PRE_INV,
        LCR_ASYNC_PRE_CLR, LCR_ASYNC_LOAD_CLR, LCR_ASYNC_LOAD_PRE, LCR_ASYNC_LOAD
    } lcr_async_e;
endpackage

module lcr_cell (
    // Clock and reset
    input  logic                         sys_clk,
    input  logic                         rst_n,
    // Register controls
    input  logic                         tick,
    input  logic                         reg_clr,
    input  logic                         reg_pre,
    // Data inputs and chains
    input  logic [lcr_pkg::DATA_W-1:0]   data,
    input  logic                         carry_in,
    input  logic                         casc_in,
    // Configuration
    input  logic [lcr_pkg::LUT_BITS-1:0] lut_mask,
    input  lcr_pkg::lcr_mode_e           mode,
    input  logic                         casc_or,
    input  logic                         inv,
    input  logic                         ce_use_d1,
    // Outputs
    output logic                         q_out,
    output logic                         comb_out,
    output logic                         casc_out,
    output logic                         carry_out
);
    import lcr_pkg::*;

    logic s_reg;
    logic reg_in;
    logic carry_w;

    // ==========================================================
    // Look-up table and cascade
    wire lut_w = lut_mask[data];
    assign casc_out = casc_or ? ~(~lut_w & ~casc_in) : (lut_w & casc_in);

    // Async controls act on the output at once, the store follows at the edge
    wire q_int   = reg_clr ? 1'b0 : (reg_pre ? 1'b1 : s_reg);
    assign q_out = q_int ^ inv;
    wire fb      = q_out;

    wire sum_w   = data[0] ^ data[1] ^ carry_in;
    wire maj_w   = (data[0] & data[1]) | (data[0] & carry_in) | (data[1] & carry_in);
    wire cnt_w   = fb ^ carry_in;
    wire ud_next = data[2] ? data[3] : cnt_w;
    wire cc_next = data[1] ? 1'b0 : cnt_w;

    // ==========================================================
    // Mode steering
    // four modes
    always_comb begin
        case (mode)
            LCR_NORMAL: begin
                reg_in  = casc_out;
                carry_w = 1'b0;
            end
            LCR_ARITH: begin
                reg_in  = sum_w;
                carry_w = maj_w;
            end
            LCR_UPDOWN: begin
                reg_in  = ud_next;
                carry_w = data[1] ? (fb & carry_in) : (~fb & carry_in);
            end
            LCR_CLRCNT: begin
                reg_in  = cc_next;
                carry_w = fb & carry_in;
            end
            default: begin
                reg_in  = casc_out;
                carry_w = 1'b0;
            end
        endcase
    end
    assign carry_out = carry_w;
    assign comb_out  = reg_in;

    wire ce      = ~ce_use_d1 | data[D1_BIT];
    wire async_w = reg_clr | reg_pre;

    // ==========================================================
    // Cell register
    // clock, clear, preset
    // clear wins, resume on enabled edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= 1'b0;
        end else if (async_w) begin
            s_reg <= ~reg_clr;
        end else if (tick && ce) begin
            s_reg <= reg_in ^ inv;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb_cell @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ce_hold_a: assert property (tick && ce_use_d1 && !data[D1_BIT] && !async_w
        |=> s_reg == $past(s_reg)) else $error("register moved with enable low");
    clear_wins_a: assert property (reg_clr |=> !s_reg)
        else $error("clear did not empty the register");
    idle_hold_a: assert property (!async_w && !(tick && ce) |=> $stable(s_reg))
        else $error("register moved without enabled tick");
    arith_sum_a: assert property (mode == LCR_ARITH && tick && ce && !async_w
        |=> s_reg == ($past(sum_w) ^ $past(inv))) else $error("sum not stored");
    clr_count_a: assert property (mode == LCR_CLRCNT && data[1] && tick && ce && !async_w
        |=> s_reg == $past(inv)) else $error("counter not cleared");
endmodule

// File: lcr_fabric.sv
`timescale 1ns/1ps
module lcr_fabric #(
    parameter int CLUSTERS = 4
) (
    // Clock and reset
    input  logic                                       sys_clk,
    input  logic                                       rst_n,
    // AHB-Lite slave
    input  logic                                       hsel,
    input  logic [31:0]                                haddr,
    input  logic [1:0]                                 htrans,
    input  logic                                       hwrite,
    input  logic [2:0]                                 hsize,
    input  logic [31:0]                                hwdata,
    input  logic                                       hready,
    output logic                                       hreadyout,
    output logic                                       hresp,
    output logic [31:0]                                hrdata,
    // Cell array
    input  logic [CLUSTERS*lcr_pkg::CPC*lcr_pkg::DATA_W-1:0] cell_data,
    output logic [CLUSTERS*lcr_pkg::CPC-1:0]           cell_q,
    output logic [CLUSTERS*lcr_pkg::CPC-1:0]           cell_casc,
    output logic [CLUSTERS*lcr_pkg::CPC-1:0]           cell_carry
);
    import lcr_pkg::*;

    localparam int N      = CLUSTERS * CPC;
    localparam int CIDX_W = $clog2(N);
    localparam int KIDX_W = $clog2(CLUSTERS);

    // ==========================================================
    // Helpers
    function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
                                      input int cnt);
        int off;
        off = int'(a) - int'(base);
        return (off >= 0) && (off < cnt * 4) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [11:0] word_index(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        return {2'h0, d[11:2]};
    endfunction

    function automatic int prev_cell(input int i, input int ncl);
        int k;
        int j;
        int half;
        k = i / CPC;
        j = i % CPC;
        half = ncl / 2;
        if (j != 0) return i - 1;
        if (k >= 2 && ((k >= half) == (k - 2 >= half))) return (k - 2) * CPC + CPC - 1;
        return -1;
    endfunction

    function automatic logic forced_inv(input logic [2:0] sch);
        return (sch == LCR_ASYNC_PRE_INV) || (sch == LCR_ASYNC_LOAD_PRE);
    endfunction

    // Returns {clear, preset} for the cell register; lval is already inverted as needed
    function automatic logic [1:0] async_decode(input logic [2:0] sch, input logic ca,
                                                input logic cb, input logic lval);
        logic ld;
        logic line_clr;
        logic clr;
        logic pre;
        ld = 1'b0;
        line_clr = 1'b0;
        case (lcr_async_e'(sch))
            LCR_ASYNC_CLR: line_clr = ca | cb;
            LCR_ASYNC_PRE, LCR_ASYNC_LOAD: ld = ca;
            LCR_ASYNC_PRE_INV: line_clr = ca;
            // preset-clear: load third input by A, clear by B
            // load by A, clear by B
            LCR_ASYNC_PRE_CLR, LCR_ASYNC_LOAD_CLR, LCR_ASYNC_LOAD_PRE: begin
                ld = ca;
                line_clr = cb;
            end
            default: ld = 1'b0;
        endcase
        clr = line_clr | (ld & ~lval);
        pre = ld & lval & ~clr;
        return {clr, pre};
    endfunction

    // ==========================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rst_s_n = rst_sync_reg;

    // ==========================================================
    // AHB-Lite slave: writes zero wait, reads one wait state
    logic [11:0]         addr_reg;
    logic                wvalid_reg;
    logic                rd_pend_reg;
    logic [31:0]         rdata_reg;
    logic [CFG_W-1:0]    cell_cfg_reg [N];
    logic [SCHEME_W-1:0] clus_scheme_reg [CLUSTERS];
    logic [CTRL_W-1:0]   ctrl_reg;
    logic [DIV_W-1:0]    div_reg;
    logic [DIV_W-1:0]    div_cnt_reg;

    wire        take      = hsel && htrans[1] && hready;
    wire [11:0] ra        = addr_reg;
    wire        cell_hit  = in_range(ra, CELL_BASE, N);
    wire        clus_hit  = in_range(ra, CLUS_BASE, CLUSTERS);
    wire [11:0] cell_full = word_index(ra, CELL_BASE);
    wire [11:0] clus_full = word_index(ra, CLUS_BASE);
    wire [CIDX_W-1:0] ra_cell = cell_full[CIDX_W-1:0];
    wire [KIDX_W-1:0] ra_clus = clus_full[KIDX_W-1:0];
    wire [31:0] out_w     = 32'(cell_q);
    wire [31:0] comb_w    = 32'(cell_casc);

    wire [31:0] rd_value =
        cell_hit          ? {{(32-CFG_W){1'b0}}, cell_cfg_reg[ra_cell]} :
        clus_hit          ? {{(32-SCHEME_W){1'b0}}, clus_scheme_reg[ra_clus]} :
        (ra == CTRL_OFF)  ? {{(32-CTRL_W){1'b0}}, ctrl_reg} :
        (ra == DIV_OFF)   ? {{(32-DIV_W){1'b0}}, div_reg} :
        (ra == OUT_OFF)   ? out_w :
        (ra == COMB_OFF)  ? comb_w : 32'h0;

    // Registered read data costs one wait state but keeps the decode off the bus path
    assign hreadyout = ~rd_pend_reg;
    assign hresp     = RESP_OKAY;
    assign hrdata    = rdata_reg;

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            addr_reg    <= 12'h000;
            wvalid_reg  <= 1'b0;
            rd_pend_reg <= 1'b0;
            rdata_reg   <= 32'h0;
        end else begin
            wvalid_reg  <= take && hwrite;
            rd_pend_reg <= take && !hwrite;
            if (take) addr_reg <= haddr[ADDR_W-1:0];
            if (rd_pend_reg) rdata_reg <= rd_value;
        end
    end

    // Writes land at the end of the data phase; unmapped writes are dropped
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            for (int n = 0; n < N; n++) cell_cfg_reg[n] <= CFG_RESET;
            for (int c = 0; c < CLUSTERS; c++) clus_scheme_reg[c] <= LCR_ASYNC_NONE;
            ctrl_reg <= CTRL_RESET;
            div_reg  <= DIV_RESET;
        end else if (wvalid_reg) begin
            if (cell_hit) cell_cfg_reg[ra_cell] <= hwdata[CFG_W-1:0];
            if (clus_hit) clus_scheme_reg[ra_clus] <= hwdata[SCHEME_W-1:0];
            if (ra == CTRL_OFF) ctrl_reg <= hwdata[CTRL_W-1:0];
            if (ra == DIV_OFF) div_reg <= hwdata[DIV_W-1:0];
        end
    end

    // ==========================================================
    // Cell clock: one enable pulse every div_reg+1 cycles
    // At or above the limit, so a smaller divider written mid-count cannot stall the cells
    wire tick = (div_cnt_reg >= div_reg);
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            div_cnt_reg <= DIV_RESET;
        end else begin
            div_cnt_reg <= tick ? DIV_RESET : div_cnt_reg + 1'b1;
        end
    end

    default clocking cb_fab @(posedge sys_clk); endclocking
    default disable iff (!rst_s_n);

    // ==========================================================
    // Cell array
    for (genvar i = 0; i < N; i++) begin : g_cell
        localparam int K    = i / CPC;
        localparam int PREV = prev_cell(i, CLUSTERS);
        wire [CFG_W-1:0]    cfg     = cell_cfg_reg[i];
        wire [SCHEME_W-1:0] sch     = clus_scheme_reg[K];
        wire                ca      = ctrl_reg[K];
        wire                cb      = ctrl_reg[CTRL_B_LSB + K];
        wire                d3      = cell_data[DATA_W * i + D3_BIT];
        wire                inv     = cfg[CFG_INV] | forced_inv(sch);
        wire                casc_or = cfg[CFG_CASC_OR];
        wire                link    = cfg[CFG_CHAIN];
        // third input driver inverted with output
        wire [1:0]          ctl     = async_decode(sch, ca, cb, d3 ^ inv);
        wire                casc_in;
        wire                carry_in;

        if (PREV >= 0) begin : g_link
            assign casc_in  = link ? cell_casc[PREV] : ~casc_or;
            assign carry_in = link & cell_carry[PREV];
        end else begin : g_head
            assign casc_in  = ~casc_or;
            assign carry_in = 1'b0;
        end

        lcr_cell u_cell (
            .sys_clk   (sys_clk),
            .rst_n     (rst_s_n),
            .tick      (tick),
            .reg_clr   (ctl[1]),
            .reg_pre   (ctl[0]),
            .data      (cell_data[DATA_W*i +: DATA_W]),
            .carry_in  (carry_in),
            .casc_in   (casc_in),
            .lut_mask  (cfg[LUT_BITS-1:0]),
            .mode      (lcr_mode_e'(cfg[CFG_MODE +: 2])),
            .casc_or   (casc_or),
            .inv       (inv),
            .ce_use_d1 (cfg[CFG_CE_D1]),
            .q_out     (cell_q[i]),
            .comb_out  (),
            .casc_out  (cell_casc[i]),
            .carry_out (cell_carry[i])
        );

        clr_scheme_a: assert property (sch == LCR_ASYNC_CLR && (ca || cb) |-> !cell_q[i])
            else $error("clear scheme did not clear");
        pre_load_a: assert property (sch == LCR_ASYNC_PRE && ca && d3 |-> cell_q[i])
            else $error("preset scheme did not set");
        inv_preset_a: assert property (sch == LCR_ASYNC_PRE_INV && ca |-> cell_q[i])
            else $error("inverted clear did not preset");
        pre_clr_a: assert property (sch == LCR_ASYNC_PRE_CLR && ca && !cb && d3
            |-> cell_q[i]) else $error("preset line did not set");
        load_clr_a: assert property (sch == LCR_ASYNC_LOAD_CLR && ca && !cb
            |-> cell_q[i] == d3) else $error("load with clear wrong");
        load_pre_a: assert property (sch == LCR_ASYNC_LOAD_PRE && ca && !cb
            |-> cell_q[i] == d3) else $error("load with preset wrong");
        load_only_a: assert property (sch == LCR_ASYNC_LOAD && ca |-> cell_q[i] == d3)
            else $error("plain load wrong");
        clr_first_a: assert property (sch == LCR_ASYNC_LOAD_CLR && ca && cb
            |-> !cell_q[i] ##1 !(ca && cb) || !cell_q[i]) else $error("clear lost to load");
        if (PREV >= 0) begin : g_chk
            casc_and_a: assert property (link && !casc_or && cell_casc[i]
                |-> cell_casc[PREV]) else $error("AND cascade ignored predecessor");
            casc_or_a: assert property (link && casc_or && cell_casc[PREV]
                |-> cell_casc[i]) else $error("OR cascade lost predecessor");
        end
    end

    // ==========================================================
    // Bus checks
    sequence read_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    read_wait_a: assert property (take && !hwrite |=> read_wait_s)
        else $error("read did not take one wait state");
    write_fast_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    div_write_a: assert property (wvalid_reg && ra == DIV_OFF
        |=> div_reg == $past(hwdata[DIV_W-1:0])) else $error("divider write lost");
    ctrl_write_a: assert property (wvalid_reg && ra == CTRL_OFF
        |=> ctrl_reg == $past(hwdata[CTRL_W-1:0])) else $error("control write lost");
    unmapped_rd_a: assert property (rd_pend_reg && !cell_hit && !clus_hit && ra > COMB_OFF
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!rd_pend_reg |=> $stable(hrdata))
        else $error("read data moved without a read");

    // Divider gap: no second pulse right after one while the limit is nonzero
    tick_gap_a: assert property (tick && div_reg != '0 && !wvalid_reg |=> !tick)
        else $error("cell clock pulsed too early");
endmodule

// File: lcr_tb.sv
`timescale 1ns/1ps
module testbench;
    import lcr_pkg::*;
    // ==========================================================
    // Signals
    logic         sys_clk;
    logic         rst_n;
    logic         hsel;
    logic         hwrite;
    logic         hreadyout;
    logic         hresp;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  haddr;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic [31:0]  rd;
    logic [255:0] cell_data;
    logic [63:0]  cell_q;
    logic [63:0]  cell_casc;
    logic [63:0]  cell_carry;
    int           err_total;
    int           n_tests;
    // Entry: scheme, lut all ones, line a, line b, third input, expected q
    logic [7:0]   atab [16] = '{8'h38, 8'h34, 8'h4b, 8'h69, 8'h8b, 8'h8e, 8'hab, 8'hb8,
                                8'hb6, 8'hc5, 8'hcb, 8'hd8, 8'heb, 8'hf8, 8'h1d, 8'hbe};

    // Eight clusters so that both row halves have an even and an odd hop
    lcr_fabric #(.CLUSTERS(8)) u_lcr_fabric (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cell_data(cell_data),
        .cell_q(cell_q), .cell_casc(cell_casc), .cell_carry(cell_carry));

    // ==========================================================
    // Bus and compare helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Ready seen at the negedge is what the next rising edge samples
    task automatic rdy();
        do @(negedge sys_clk); while (hreadyout !== 1'b1);
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        haddr  <= {20'h0, a};
        hwrite <= 1'b1;
        htrans <= 2'b10;
        rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        haddr  <= {20'h0, a};
        hwrite <= 1'b0;
        htrans <= 2'b10;
        rdy();
        htrans <= 2'b00;
        do @(negedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge sys_clk);
        chk(rd, e);
        chk({31'h0, hresp}, {31'h0, RESP_OKAY});
    endtask
    task automatic q_at(input int i, input logic e);
        @(negedge sys_clk);
        chk({31'h0, cell_q[i]}, {31'h0, e});
        @(posedge sys_clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_chk(CTRL_OFF, 32'h0);
        rd_chk(CELL_BASE, 32'h0);
        wr(DIV_OFF, 32'hffffffff);
        rd_chk(DIV_OFF, 32'h0000ffff);
        wr(DIV_OFF, 32'h0);
        wr(12'h040, 32'hffffffff);
        rd_chk(12'h040, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_casc();
        for (int i = 0; i < 40; i++) begin
            cell_data[4*i +: 4] <= 4'hf;
            wr(CELL_BASE + 12'(4 * i),
               (i % 8 != 0 || i == 16 || i == 32) ? 32'h00048000 : 32'h00008000);
        end
        wr(CELL_BASE + 12'h0a0, 32'h00088000);
        wr(CELL_BASE + 12'h0a4, 32'h000c8000);
        cell_data[160 +: 4] <= 4'hf;
        @(negedge sys_clk);
        chk({31'h0, cell_casc[23]}, 32'h1);
        chk({31'h0, cell_casc[41]}, 32'h1);
        @(posedge sys_clk);
        cell_data[12 +: 4] <= 4'h0;
        @(negedge sys_clk);
        chk({31'h0, cell_casc[23]}, 32'h0);
        chk({31'h0, cell_casc[39]}, 32'h1);
        @(posedge sys_clk);
        cell_data[140 +: 4] <= 4'h0;
        @(negedge sys_clk);
        chk({31'h0, cell_casc[39]}, 32'h0);
        @(posedge sys_clk);
        rd_chk(COMB_OFF, 32'hff00ff07);
        rd_chk(OUT_OFF, 32'hff00ff07);
        $display("test cascade done");
    endtask
    task automatic t_modes();
        @(posedge sys_clk);
        wr(CELL_BASE + 12'h0c0, 32'h00010000);
        cell_data[192 +: 4] <= 4'h3;
        @(negedge sys_clk);
        chk({31'h0, cell_carry[48]}, 32'h1);
        @(posedge sys_clk);
        wr(CELL_BASE + 12'h0c4, 32'h00020000);
        cell_data[196 +: 4] <= 4'hc;
        repeat (2) @(posedge sys_clk);
        q_at(49, 1'b1);
        wr(CELL_BASE + 12'h0c4, 32'h00030000);
        cell_data[196 +: 4] <= 4'h2;
        repeat (2) @(posedge sys_clk);
        q_at(49, 1'b0);
        $display("test modes done");
    endtask
    task automatic t_async();
        logic [7:0] e;
        for (int k = 0; k < 16; k++) begin
            e = atab[k];
            wr(CLUS_BASE + 12'h004, {29'h0, e[7:5]});
            wr(CELL_BASE + 12'h020, {16'h0, {16{e[4]}}});
            cell_data[32 +: 4] <= {1'b0, e[1], 2'b00};
            repeat (3) @(posedge sys_clk);
            wr(CTRL_OFF, {22'h0, e[2], 7'h0, e[3], 1'b0});
            // Checked in the cycle the write lands: no clock edge may be needed
            q_at(8, e[0]);
            wr(CTRL_OFF, 32'h0);
            repeat (2) @(posedge sys_clk);
            q_at(8, e[4]);
        end
        $display("test async done");
    endtask
    task automatic t_ce();
        wr(CLUS_BASE + 12'h004, 32'h1);
        wr(CELL_BASE + 12'h020, 32'h0020ffff);
        cell_data[32 +: 4] <= 4'h0;
        wr(CTRL_OFF, 32'h2);
        wr(CTRL_OFF, 32'h0);
        repeat (4) @(posedge sys_clk);
        q_at(8, 1'b0);
        cell_data[32 +: 4] <= 4'h1;
        repeat (2) @(posedge sys_clk);
        q_at(8, 1'b1);
        $display("test enable done");
    endtask

    // ==========================================================
    // Run control
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        hsel = 1'b1;
        hsize = 3'b010;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        cell_data = '0;
        err_total = 0;
        n_tests = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_casc();
        t_modes();
        t_async();
        t_ce();
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #2000000;
        err_total++;
        end_of_test();
    end
endmodule
